/* logic/scan_test_access_port.sv */
`timescale 1ns/100ps
// Behaviour
// RULE1: Test reset high gives scan system control.
// RULE2: Test reset low: functional mode, inputs ignored.
// RULE3: Probe keeps test reset low normally.
// RULE4: Mode select sampled on rising test clock.
// RULE5: Data input captured on rising test clock.
// RULE6: Selected register shifted out on falling edge.
// RULE7: Test pins come up in test function.
module scan_test_access_port
   import scan_tap_pkg::*;
#(
   parameter int DR_W = DR_WIDTH
)
(
   // Core clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Probe link
   input  wire logic        tck,
   input  wire logic        trst,
   input  wire probe_in_t   probe,
   output logic             tdo,
   output logic             tdo_oe,
   // Core status
   output logic             scan_mode,
   output logic             test_pins_active,
   output logic             gpio_default,
   output logic [DR_W-1:0]  user_word,
   output logic             user_word_stb
);

   tap_state_t           state;
   logic                 sel_user;
   logic                 byp;
   logic                 ir_sout;
   logic                 dr_sout;
   logic                 shift_out;
   logic                 in_shift;
   logic                 upd_tgl;
   logic [IR_WIDTH-1:0]  instr;
   logic [DR_W-1:0]      dr_par;
   logic [SYNC_STAGES-1:0] trst_s;
   logic [SYNC_STAGES-1:0] tgl_s;
   logic                 tgl_seen;

   if (DR_W < 2)
   begin : g_chk
      $error("scan_test_access_port needs DR_W of at least 2");
   end

   // ------------------------------------------------------------
   // Controller next state
   // ------------------------------------------------------------
   function automatic tap_state_t next_state(input tap_state_t s, input logic m);
      tap_state_t n;
      n = TAP_RESET;
      case (s)
         TAP_RESET:    n = m ? TAP_RESET    : TAP_IDLE;
         TAP_IDLE:     n = m ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_DR:   n = m ? TAP_SEL_IR   : TAP_CAP_DR;
         TAP_CAP_DR:   n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: n = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
         TAP_PAUSE_DR: n = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: n = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
         TAP_UPD_DR:   n = m ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_IR:   n = m ? TAP_RESET    : TAP_CAP_IR;
         TAP_CAP_IR:   n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: n = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
         TAP_PAUSE_IR: n = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: n = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
         TAP_UPD_IR:   n = m ? TAP_SEL_DR   : TAP_IDLE;
         default:      n = TAP_RESET;
      endcase
      return n;
   endfunction

   // ------------------------------------------------------------
   // Link side, test clock domain, held in reset by low test reset
   // ------------------------------------------------------------
   // RULE2 held reset
   // RULE4 rising edge sample
   always_ff @(posedge tck or negedge trst)
   begin
      if (!trst)
         state <= TAP_RESET;
      else
         state <= next_state(state, probe.mode_sel);
   end

   assign sel_user = (instr == INSTR_USER);
   assign in_shift = (state == TAP_SHIFT_IR) || (state == TAP_SHIFT_DR);

   // RULE5 instruction capture
   scan_shift_reg #(.W(IR_WIDTH)) u_ir
   (
      .clk       (tck),
      .rst_b     (trst),
      .clear     (state == TAP_RESET),
      .capture   (state == TAP_CAP_IR),
      .shift     (state == TAP_SHIFT_IR),
      .update    (state == TAP_UPD_IR),
      .cap_val   (IR_CAPTURE),
      .reset_val (INSTR_BYPASS),
      .sin       (probe.data_in),
      .sout      (ir_sout),
      .par       (instr)
   );

   // RULE5 data capture
   scan_shift_reg #(.W(DR_W)) u_dr
   (
      .clk       (tck),
      .rst_b     (trst),
      .clear     (1'b0),
      .capture   ((state == TAP_CAP_DR) && sel_user),
      .shift     ((state == TAP_SHIFT_DR) && sel_user),
      .update    ((state == TAP_UPD_DR) && sel_user),
      .cap_val   (dr_par),
      .reset_val ('0),
      .sin       (probe.data_in),
      .sout      (dr_sout),
      .par       (dr_par)
   );

   // RULE5 bypass capture
   always_ff @(posedge tck or negedge trst)
   begin
      if (!trst)
         byp <= BYPASS_CAP;
      else if (state == TAP_CAP_DR)
         byp <= BYPASS_CAP;
      else if (state == TAP_SHIFT_DR)
         byp <= probe.data_in;
   end

   // Event toggle toward the core
   always_ff @(posedge tck or negedge trst)
   begin
      if (!trst)
         upd_tgl <= 1'b0;
      else if ((state == TAP_UPD_DR) && sel_user)
         upd_tgl <= ~upd_tgl;
   end

   always_comb
   begin
      if (state == TAP_SHIFT_IR)
         shift_out = ir_sout;
      else if (sel_user)
         shift_out = dr_sout;
      else
         shift_out = byp;
   end

   // RULE6 falling edge output
   always_ff @(negedge tck or negedge trst)
   begin
      if (!trst)
      begin
         tdo    <= TDO_IDLE;
         tdo_oe <= 1'b0;
      end
      else
      begin
         tdo    <= shift_out;
         tdo_oe <= in_shift;
      end
   end

   // ------------------------------------------------------------
   // Core side, core clock domain
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         trst_s <= '0;
         tgl_s  <= '0;
      end
      else
      begin
         trst_s <= {trst_s[SYNC_STAGES-2:0], trst};
         tgl_s  <= {tgl_s[SYNC_STAGES-2:0], upd_tgl};
      end
   end

   // RULE1 scan control
   // RULE2 functional mode
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         scan_mode <= 1'b0;
      else if (trst_s[1] == trst_s[2])
         scan_mode <= trst_s[2];
   end

   // RULE7 pin function default
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         test_pins_active <= 1'b1;
         gpio_default     <= 1'b1;
      end
      else
      begin
         test_pins_active <= 1'b1;
         gpio_default     <= 1'b1;
      end
   end

   // Update word handover, word stable while toggle settles
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tgl_seen      <= 1'b0;
         user_word     <= '0;
         user_word_stb <= 1'b0;
      end
      else if ((tgl_s[1] == tgl_s[2]) && (tgl_s[2] != tgl_seen))
      begin
         tgl_seen      <= tgl_s[2];
         user_word     <= dr_par;
         user_word_stb <= 1'b1;
      end
      else
         user_word_stb <= 1'b0;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   scan_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
      trst [*4] |=> scan_mode)
      else $error("scan control not taken with test reset high");

   func_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
      !trst [*4] |=> !scan_mode)
      else $error("functional mode not kept with test reset low");

   // Raw test reset: link logic must sit idle at once, not after the sync delay
   tap_held_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
      !trst |-> (state == TAP_RESET) && !tdo_oe && (tdo == TDO_IDLE))
      else $error("link logic active while test reset low");

   pin_func_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE7
      test_pins_active && gpio_default)
      else $error("pin function default lost");

   tms_reset_a: assert property (@(posedge tck) disable iff (!trst) // RULE4
      probe.mode_sel [*5] |=> (state == TAP_RESET))
      else $error("five high mode select did not reach reset");

   tms_step_a: assert property (@(posedge tck) disable iff (!trst) // RULE4
      (state == TAP_IDLE) && probe.mode_sel |=> (state == TAP_SEL_DR))
      else $error("mode select not sampled on rising edge");

   tdi_bypass_a: assert property (@(posedge tck) disable iff (!trst) // RULE5
      (state == TAP_SHIFT_DR) && !sel_user |=> (byp == $past(probe.data_in)))
      else $error("data input not captured in bypass");

   tdo_fall_a: assert property (@(negedge tck) disable iff (!trst) // RULE6
      1'b1 |=> (tdo == $past(shift_out)) && (tdo_oe == $past(in_shift)))
      else $error("data output not shifted on falling edge");

   scan_rise_c: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(scan_mode));
   user_upd_c:  cover property (@(posedge core_clk) disable iff (!rst_b) user_word_stb);
   ir_shift_c:  cover property (@(posedge tck) disable iff (!trst) state == TAP_SHIFT_IR);
   dr_pause_c:  cover property (@(posedge tck) disable iff (!trst) state == TAP_PAUSE_DR);

endmodule

/* include/scan_tap_pkg.sv */
package scan_tap_pkg;

   // ------------------------------------------------------------
   // Register sizes and codes
   // ------------------------------------------------------------
   localparam int         IR_WIDTH      = 4;
   localparam int         DR_WIDTH      = 32;
   localparam logic [3:0] IR_CAPTURE    = 4'h1;
   localparam logic [3:0] INSTR_BYPASS  = 4'hF;
   localparam logic [3:0] INSTR_USER    = 4'h2;
   localparam logic       BYPASS_CAP    = 1'h0;
   localparam logic       TDO_IDLE      = 1'h0;
   localparam int         SYNC_STAGES   = 3;

   // ------------------------------------------------------------
   // Test access port controller states
   // ------------------------------------------------------------
   typedef enum logic [3:0]
   {
      TAP_RESET     = 4'b0000,
      TAP_IDLE      = 4'b0001,
      TAP_SEL_DR    = 4'b0010,
      TAP_CAP_DR    = 4'b0011,
      TAP_SHIFT_DR  = 4'b0100,
      TAP_EXIT1_DR  = 4'b0101,
      TAP_PAUSE_DR  = 4'b0110,
      TAP_EXIT2_DR  = 4'b0111,
      TAP_UPD_DR    = 4'b1000,
      TAP_SEL_IR    = 4'b1001,
      TAP_CAP_IR    = 4'b1010,
      TAP_SHIFT_IR  = 4'b1011,
      TAP_EXIT1_IR  = 4'b1100,
      TAP_PAUSE_IR  = 4'b1101,
      TAP_EXIT2_IR  = 4'b1110,
      TAP_UPD_IR    = 4'b1111
   } tap_state_t;

   // ------------------------------------------------------------
   // Probe inputs sampled on the test clock
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic mode_sel;
      logic data_in;
   } probe_in_t;

endpackage

/* logic/scan_shift_reg.sv */
`timescale 1ns/100ps
module scan_shift_reg
   import scan_tap_pkg::*;
#(
   parameter int W = IR_WIDTH
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // Control
   input  wire logic         clear,
   input  wire logic         capture,
   input  wire logic         shift,
   input  wire logic         update,
   // Data
   input  wire logic [W-1:0] cap_val,
   input  wire logic [W-1:0] reset_val,
   input  wire logic         sin,
   output logic              sout,
   output logic [W-1:0]      par
);

   logic [W-1:0] sh;

   if (W < 2)
   begin : g_chk
      $error("scan_shift_reg needs W of at least 2");
   end

   // ------------------------------------------------------------
   // Shift stage, least significant bit first out
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         sh <= '0;
      else if (capture)
         sh <= cap_val;
      else if (shift)
         sh <= {sin, sh[W-1:1]};
   end

   // ------------------------------------------------------------
   // Update stage
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         par <= '0;
      else if (clear)
         par <= reset_val;
      else if (update)
         par <= sh;
   end

   assign sout = sh[0];

endmodule

/* verif/probe_model.sv */
`timescale 1ns/100ps
module probe_model
   import scan_tap_pkg::*;
(
   // Link
   output logic      tck,
   output logic      trst,
   output probe_in_t probe,
   input  wire logic tdo
);
   // test reset held low until asked
   initial
   begin
      tck   = 1'h0;
      trst  = 1'h0;
      probe = 2'h3;
   end

   task automatic hold_trst(input logic v);
      trst = v;
   endtask

   // inputs set after fall, taken at rise
   task automatic step(input logic ms, input logic di, output logic so);
      probe = {ms, di};
      #3;
      so  = tdo;
      tck = 1'h1;
      #3;
      tck = 1'h0;
   endtask

   task automatic walk_reset();
      logic so;
      for (int i = 0; i < 6; i++)
         step(i < 5, 1'h1, so);
   endtask

   // One scan from idle, LSB first, optional pause after bit h, back to idle
   task automatic scan(input logic ir, input int n, input int h, input logic [63:0] din,
                       output logic [63:0] dout);
      logic so;
      int   k;
      k    = ir ? 4 : 3;
      dout = '0;
      for (int i = 0; i < k; i++)
         step(i < k - 2, 1'h1, so);
      for (int i = 0; i < n; i++)
      begin
         step((i == n - 1) || (i == h), din[i], dout[i]);
         // Exit, pause, then resume shifting
         if ((i == h) && (i != n - 1))
         begin
            step(1'h0, 1'h1, so);
            step(1'h1, 1'h1, so);
            step(1'h0, 1'h1, so);
         end
      end
      step(1'h1, 1'h1, so);
      step(1'h0, 1'h1, so);
      // Lines go back to their pull-up level, half a period before any next scan
      probe = 2'h3;
      #3;
   endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import scan_tap_pkg::*;
   localparam int DW = 16;
   logic          core_clk;
   logic          rst_b;
   logic          tck;
   logic          trst;
   logic          tdo;
   logic          tdo_oe;
   logic          scan_mode;
   logic          test_pins_active;
   logic          gpio_default;
   logic          user_word_stb;
   logic [DW-1:0] user_word;
   probe_in_t     probe;
   logic [63:0]   dout;
   logic [63:0]   prev;
   logic [63:0]   w;
   int            num_errors;
   int            comparisons;
   int            stb_count;

   scan_test_access_port #(.DR_W(DW)) DUT (
      .core_clk(core_clk), .rst_b(rst_b), .tck(tck), .trst(trst), .probe(probe), .tdo(tdo),
      .tdo_oe(tdo_oe), .scan_mode(scan_mode), .test_pins_active(test_pins_active),
      .gpio_default(gpio_default), .user_word(user_word), .user_word_stb(user_word_stb));

   probe_model P (.tck(tck), .trst(trst), .probe(probe), .tdo(tdo));

   initial
   begin
      core_clk    = 1'h0;
      rst_b       = 1'h0;
      num_errors  = 0;
      comparisons = 0;
      stb_count   = 0;
   end

   always #2 core_clk = ~core_clk;

   always @(posedge core_clk)
      if (user_word_stb === 1'h1)
         stb_count++;

   function automatic logic [7:0] bypass_exp(input logic [7:0] x);
      return {x[6:0], BYPASS_CAP};
   endfunction

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'h1)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic end_of_test();
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #50000;
      num_errors++;
      end_of_test();
   end

   initial
   begin
      void'($urandom(32'h77DE));
      repeat (20) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (2) @(posedge core_clk);
      check(test_pins_active === 1'h1 && gpio_default === 1'h1, "pin function");
      P.scan(1'h0, 8, -1, 64'hFF, dout);
      check(dout[7:0] === 8'h00 && tdo_oe === 1'h0 && scan_mode === 1'h0, "not functional");
      P.hold_trst(1'h1);
      repeat (8) @(posedge core_clk);
      check(scan_mode === 1'h1, "scan mode not taken");
      P.walk_reset();
      P.scan(1'h1, 4, -1, 64'(INSTR_USER), dout);
      check(dout[3:0] === IR_CAPTURE, "ir capture");
      prev = '0;
      for (int i = 0; i < 6; i++)
      begin
         w = {$urandom, $urandom};
         if (i == 1)
            w = '1;
         if (i == 2)
            w = 64'h1;
         P.scan(1'h0, DW, (i == 3) ? 5 : -1, w, dout);
         if (i > 0)
            check(dout[DW-1:0] === prev[DW-1:0], "dr readback");
         repeat (10) @(posedge core_clk);
         check(user_word === w[DW-1:0] && stb_count == i + 1, "user word");
         prev = w;
      end
      P.scan(1'h1, 4, -1, 64'(INSTR_BYPASS), dout);
      check(dout[3:0] === IR_CAPTURE, "ir capture bypass");
      w = 64'($urandom);
      P.scan(1'h0, 8, -1, w, dout);
      check(dout[7:0] === bypass_exp(w[7:0]), "bypass path");
      repeat (10) @(posedge core_clk);
      check(stb_count == 6 && user_word === prev[DW-1:0], "bypass updated word");
      P.hold_trst(1'h0);
      repeat (8) @(posedge core_clk);
      check(scan_mode === 1'h0 && tdo === 1'h0 && tdo_oe === 1'h0, "release");
      end_of_test();
   end
endmodule
